// ---- shared/abce_pkg.sv ----
// Package for the ALU, bit and call execution block.
// Assumes a single core clock domain and synchronous active-high reset.
package abce_pkg;
    // ========================================================
    // Widths, field positions, reset values and cycle counts
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 10;
    localparam int HALF_BIT = 4;
    localparam int CARRY_BIT = 8;
    localparam int PAGE_SRC_BIT = 5;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [9:0] PC_RESET = 10'h000;
    localparam logic [1:0] CALL_CYCLES = 2'h2;
    localparam logic [1:0] SKIP_CYCLES = 2'h2;
    localparam logic [1:0] ONE_CYCLE = 2'h1;

    // Operation selector
    typedef enum logic [3:0] {
        ABCE_NOP,
        ABCE_ADD_IMM,
        ABCE_ADD_IMM_C,
        ABCE_ADD_REG,
        ABCE_AND_REG,
        ABCE_AND_IMM,
        ABCE_BIT_CLR,
        ABCE_BIT_SET,
        ABCE_SKIP_SET,
        ABCE_CALL
    } abce_op_t;

    // Decoded instruction
    typedef struct packed {
        abce_op_t op;
        logic [7:0] imm;
        logic [6:0] addr;
        logic [2:0] bitpos;
        logic dest;
    } abce_instr_t;

    // Status flags
    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
    } abce_flags_t;
endpackage : abce_pkg

// ---- logic/abce_core.sv ----
// Execution core for add, and, bit clear/set, skip-if-set and short call.
// Assumes decoded instructions and a data register read value on the
// same cycle the instruction is presented; writes are taken by the file.
`timescale 1ns/1ps
`default_nettype none
module abce_core
    import abce_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Instruction in
    input wire logic instr_valid,
    input wire abce_instr_t instr,
    input wire logic [PC_W-1:0] pc_now,
    input wire logic [7:0] status_reg,
    // Data register file
    input wire logic [7:0] reg_rdata,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    // Stack and program counter
    output logic push_en,
    output logic [PC_W-1:0] push_addr,
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    // Pipeline control
    output logic discard_prefetch,
    output logic busy,
    // State
    output logic [7:0] working_register,
    output abce_flags_t flags
);
    // ========================================================
    // Arithmetic decode
    wire logic is_add_imm = instr.op == ABCE_ADD_IMM;
    wire logic is_adc = instr.op == ABCE_ADD_IMM_C;
    wire logic is_add_reg = instr.op == ABCE_ADD_REG;
    wire logic is_add = is_add_imm | is_adc | is_add_reg;
    wire logic is_and = (instr.op == ABCE_AND_REG) |
                        (instr.op == ABCE_AND_IMM);
    wire logic go = instr_valid && !busy;
    // Operand B: immediate or data register
    wire logic [7:0] opnd_b = (is_add_reg || instr.op == ABCE_AND_REG) ?
                              reg_rdata : instr.imm;
    wire logic cin = is_adc ? flags.carry : 1'b0;
    // Low nibble sum gives half carry
    wire logic [4:0] low_sum = {1'b0, working_register[3:0]} +
                               {1'b0, opnd_b[3:0]} + {4'h0, cin};
    wire logic [8:0] full_sum = {1'b0, working_register} +
                                {1'b0, opnd_b} + {8'h00, cin};
    wire logic [7:0] and_res = working_register & opnd_b;
    wire logic [7:0] alu_res = is_add ? full_sum[7:0] : and_res;
    // Bit mask for clear/set/test
    wire logic [7:0] bit_mask = 8'h01 << instr.bitpos;
    wire logic [7:0] bit_res = (instr.op == ABCE_BIT_SET) ?
                               (reg_rdata | bit_mask) :
                               (reg_rdata & ~bit_mask);
    wire logic is_bit = (instr.op == ABCE_BIT_SET) |
                        (instr.op == ABCE_BIT_CLR);
    wire logic to_reg = (is_add_reg || instr.op == ABCE_AND_REG) &&
                        instr.dest;
    wire logic skip_hit = (instr.op == ABCE_SKIP_SET) &&
                          ((reg_rdata & bit_mask) != 8'h00);
    wire logic is_call = instr.op == ABCE_CALL;
    // Call target: status bit to PC9, zero PC8, immediate low
    wire logic [PC_W-1:0] call_tgt = {status_reg[PAGE_SRC_BIT], 1'b0,
                                      instr.imm};
    wire logic [PC_W-1:0] ret_addr = pc_now + 10'h001;

    // Second-cycle counter for two-cycle ops
    logic [1:0] stall_cnt;
    // Call and taken skip each load their own extra-cycle count
    wire logic [1:0] next_stall =
        (go && is_call) ? (CALL_CYCLES - ONE_CYCLE) :
        (go && skip_hit) ? (SKIP_CYCLES - ONE_CYCLE) :
        (stall_cnt != 2'h0) ? (stall_cnt - 2'h1) : 2'h0;

    // ========================================================
    // Working register and flags
    always_ff @(posedge core_clk) begin
        if (rst) begin
            working_register <= WREG_RESET;
            flags <= '0;
        end else if (go && (is_add || is_and)) begin
            if (!to_reg) begin
                working_register <= alu_res;
            end
            if (is_add) begin
                flags.carry <= full_sum[CARRY_BIT];
                flags.half_carry_flag <= low_sum[HALF_BIT];
            end
            flags.zero <= alu_res == 8'h00;
        end
    end

    // Register file write and addressing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_we <= 1'b0;
            reg_addr <= '0;
            reg_wdata <= '0;
        end else begin
            reg_we <= go && (to_reg || is_bit);
            reg_addr <= instr.addr;
            reg_wdata <= is_bit ? bit_res : alu_res;
        end
    end

    // Call, skip and stall control
    always_ff @(posedge core_clk) begin
        if (rst) begin
            push_en <= 1'b0;
            push_addr <= PC_RESET;
            pc_load <= 1'b0;
            pc_target <= PC_RESET;
            discard_prefetch <= 1'b0;
            stall_cnt <= 2'h0;
            busy <= 1'b0;
        end else begin
            push_en <= go && is_call;
            push_addr <= ret_addr;
            pc_load <= push_en; // pushed before counter changes
            pc_target <= push_en ? pc_target : call_tgt;
            discard_prefetch <= go && skip_hit;
            stall_cnt <= next_stall;
            busy <= next_stall != 2'h0;
        end
    end

    // ========================================================
    // Checks
    // All properties sample on the core clock; the assertions sleep during reset, the covers do not.
    // Reference results built apart from the adders; chk_sum and chk_and reuse the opnd_b mux
    wire logic [8:0] chk_sum = {1'b0, working_register} + {1'b0, opnd_b};
    wire logic [8:0] chk_adc = {1'b0, working_register} +
                               {1'b0, instr.imm} + {8'h00, flags.carry};
    wire logic [7:0] chk_reg = working_register + reg_rdata;
    wire logic [7:0] chk_and = working_register & opnd_b;

    // Plain immediate add lands in the working register
    add_imm_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_add_imm |=> working_register == $past(chk_sum[DATA_W-1:0]))
        else $error("add result wrong");
    // Carry in joins the sum, carry out lands in the flag
    adc_carry_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_adc |=> flags.carry == $past(chk_adc[CARRY_BIT]) &&
            working_register == $past(chk_adc[DATA_W-1:0]))
        else $error("carry add wrong");
    // Register add into the working register, zero from the sum
    add_reg_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_add_reg && !instr.dest |=>
            working_register == $past(chk_reg) &&
            flags.zero == ($past(chk_reg) == 8'h00))
        else $error("register add wrong");
    // Destination one writes back and spares the working register
    dest_reg_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_add_reg && instr.dest |=> reg_we &&
            reg_wdata == $past(chk_reg) && reg_addr == $past(instr.addr) &&
            $stable(working_register))
        else $error("destination wrong");
    // AND leaves carry and half carry alone
    and_flags_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_and |=> $stable(flags.carry) &&
            $stable(flags.half_carry_flag))
        else $error("and flags wrong");
    // AND sets zero from its own result
    and_zero_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_and |=> flags.zero == ($past(chk_and) == 8'h00))
        else $error("and zero wrong");
    // Immediate AND lands in the working register
    and_imm_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && instr.op == ABCE_AND_IMM |=>
            working_register == $past(working_register & instr.imm))
        else $error("and immediate wrong");
    // Bit clear touches only the chosen bit, flags held
    bit_clr_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && instr.op == ABCE_BIT_CLR |=> reg_we &&
            reg_wdata == ($past(reg_rdata) & ~$past(bit_mask)) &&
            $stable(flags))
        else $error("bit clear wrong");
    // Bit set touches only the chosen bit, flags held
    bit_set_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && instr.op == ABCE_BIT_SET |=> reg_we &&
            reg_wdata == ($past(reg_rdata) | $past(bit_mask)) &&
            $stable(flags))
        else $error("bit set wrong");
    // Taken skip drops the prefetch and stalls exactly one cycle
    skip_two_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && skip_hit |=> discard_prefetch && busy && $stable(flags)
            ##1 !busy)
        else $error("skip timing wrong");
    // Push comes first, the counter loads a cycle later
    call_order_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_call |=> push_en && !pc_load && $stable(flags) &&
            push_addr == $past(pc_now) + 10'h001 ##1 pc_load && !busy)
        else $error("call order wrong");
    // Call target from the status page bit and the immediate
    call_tgt_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_call |=> ##1 pc_target ==
            {$past(status_reg[PAGE_SRC_BIT], 2), 1'b0, $past(instr.imm, 2)})
        else $error("call target wrong");
    // Half carry follows the low nibble carry on every add
    half_carry_a: assert property (
        @(posedge core_clk) disable iff (rst)
        go && is_add |=> flags.half_carry_flag == $past(low_sum[HALF_BIT]))
        else $error("half carry wrong");

    // Main scenarios worth seeing at least once
    add_c: cover property (@(posedge core_clk) go && is_adc && flags.carry);
    skip_c: cover property (@(posedge core_clk) go && skip_hit);
    call_c: cover property (@(posedge core_clk) pc_load);
    bset_c: cover property (@(posedge core_clk) go && is_bit);
    wback_c: cover property (@(posedge core_clk) go && to_reg);
endmodule : abce_core
`default_nettype wire

// ---- verification/abce_regfile_model.sv ----
// Data register file model that sits beside the execution core.
// Assumes a combinational read and a write strobe on the core clock.
`timescale 1ns/1ps
`default_nettype none
module abce_regfile_model (
    // Clock
    input wire logic core_clk,
    // Read side
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data,
    // Write side
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en
);
    logic [7:0] mem [128]; // All 128 data registers
    // ========================================
    // Seeded contents, then write-back
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 53 + 7);
    always @(posedge core_clk) if (wr_en) mem[wr_addr] <= wr_data;
    assign rd_data = mem[rd_addr]; // Same-cycle read
endmodule : abce_regfile_model
`default_nettype wire

// ---- verification/abce_core_bench.sv ----
// Self-checking bench: random instructions against a reference model.
// Assumes the register file model answers reads in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module abce_core_bench;
    import abce_pkg::*;
    logic core_clk = 0, rst = 1, instr_valid = 0;
    abce_instr_t instr = '0;
    logic [9:0] pc_now = '0, push_addr, pc_target;
    logic [7:0] status_reg = '0, reg_wdata, reg_rdata, working_register;
    logic [6:0] reg_addr;
    logic reg_we, push_en, pc_load, discard_prefetch, busy;
    abce_flags_t flags;
    logic [7:0] ew = '0; // Expected working register
    logic ec = 0, eh = 0, ez = 0; // Expected flags
    int fails = 0, n_checks = 0, cyc = 0;
    // ========================================
    // Clock, timeout and instances
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end
    abce_core u_abce_core (.core_clk(core_clk), .rst(rst),
        .instr_valid(instr_valid), .instr(instr), .pc_now(pc_now),
        .status_reg(status_reg), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .push_en(push_en),
        .push_addr(push_addr), .pc_load(pc_load), .pc_target(pc_target),
        .discard_prefetch(discard_prefetch), .busy(busy),
        .working_register(working_register), .flags(flags));
    abce_regfile_model u_abce_regfile_model (.core_clk(core_clk),
        .rd_addr(instr.addr), .rd_data(reg_rdata), .wr_addr(reg_addr),
        .wr_data(reg_wdata), .wr_en(reg_we));
    // ========================================
    // Compare, sum and verdict helpers
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Sum with half carry and carry: {half, carry, sum}
    function automatic logic [9:0] add9(input logic [7:0] a, b,
                                        input logic ci);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b} + 9'(ci);
        add9 = {({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci)) > 5'h0F, s};
    endfunction : add9
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // ========================================
    // One instruction, held through the busy cycle to probe refusal
    task automatic run(input abce_op_t op, input logic [7:0] im,
                       input logic d);
        logic [7:0] rd, res, wv;
        logic we, upd, bsy;
        @(posedge core_clk);
        instr <= '{op, im, 7'($urandom), 3'($urandom), d};
        status_reg <= 8'($urandom);
        pc_now <= 10'($urandom);
        instr_valid <= 1'b1;
        #1 rd = reg_rdata;
        res = ew;
        upd = 1;
        case (op)
            ABCE_ADD_IMM, ABCE_ADD_IMM_C:
                {eh, ec, res} = add9(ew, im, op == ABCE_ADD_IMM_C && ec);
            ABCE_ADD_REG: {eh, ec, res} = add9(ew, rd, 1'b0);
            ABCE_AND_REG: res = ew & rd;
            ABCE_AND_IMM: res = ew & im;
            default: upd = 0; // Flags untouched
        endcase
        if (upd) ez = (res == 8'h00);
        we = (op == ABCE_ADD_REG || op == ABCE_AND_REG) && d;
        wv = res;
        if (upd && !we) ew = res;
        if (op == ABCE_BIT_CLR || op == ABCE_BIT_SET) begin
            we = 1;
            wv = rd;
            wv[instr.bitpos] = (op == ABCE_BIT_SET);
        end
        bsy = op == ABCE_CALL || (op == ABCE_SKIP_SET && rd[instr.bitpos]);
        @(posedge core_clk);
        instr_valid <= bsy;
        #1 chk(working_register, ew);
        chk(flags, {ec, eh, ez});
        chk(reg_we, we);
        if (we) chk(reg_addr, instr.addr);
        if (we) chk(reg_wdata, wv);
        chk(push_en, op == ABCE_CALL);
        if (op == ABCE_CALL) chk(push_addr, pc_now + 10'h001);
        chk(pc_load, 0);
        chk(discard_prefetch, op == ABCE_SKIP_SET && bsy);
        chk(busy, bsy);
        if (bsy) begin
            @(posedge core_clk);
            instr_valid <= 1'b0;
            #1 chk(busy, 0);
            chk({push_en, discard_prefetch, reg_we}, 0);
            chk(pc_load, op == ABCE_CALL);
            if (op == ABCE_CALL) begin
                chk(pc_target, {status_reg[PAGE_SRC_BIT], 1'b0, im});
            end
        end
    endtask : run
    // ========================================
    // Reset, carry corner cases, then random traffic
    initial begin
        void'($urandom(35017));
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        #1 chk(working_register, 8'h00);
        chk(flags, 3'h0);
        run(ABCE_ADD_IMM, 8'hFF, 1'b0);
        run(ABCE_ADD_IMM, 8'h01, 1'b0);
        run(ABCE_ADD_IMM_C, 8'h0F, 1'b0);
        for (int i = 0; i < 400; i++) begin
            run(abce_op_t'(4'($urandom_range(9, 1))), 8'($urandom),
                1'($urandom));
        end
        wrap_up();
    end
endmodule : abce_core_bench
`default_nettype wire
